/* File: core/flash_protect_status_guard.sv */
// Local design decision: the APB register port.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// [R1] Protection writes that would drop protection are ignored, setting kept.
// [R2] From 0 reach 0-3; 1 reach 1,3; 2 reach 2,3; 3 only 3; 4 reach 3,4.
// [R3] From 5 reach 2-5; 6 reach 1,3,4,6; 7 reach all; rest rejected.
// [R4] Reading protection returns the scenario now in force.
// [R5] Status bits have normal-mode access; unused bits read 0, ignore writes.
// [R6] Failure flag is software-writable only in special mode.
// [R7] Software clears failure flag before starting a new command sequence.
// [R8] Buffer-empty flag set when buffers empty; write 1 clears, 0 keeps.
// [R9] Writing 0 to buffer-empty mid-sequence aborts it and flags access error.
// [R10] Writing 0 to buffer-empty outside a sequence sets no access error.
// [R11] Buffer-empty flag with its enable raises an interrupt request.
// [R12] Complete flag clears while buffer-empty clear; sets when all commands done.
// [R13] Complete flag stays clear if a pending command is fetched at once.
// [R14] Complete flag ignores writes; with its enable raises an interrupt.
// [R15] Violation flag set on protected program/erase; write 1 clears.
// [R16] Violation flag set blocks launches and new sequences.
// [R17] Access error set by sequence errors, bad codes, abort, fault, stop.
// [R18] Access error clears on write 1; while set blocks launches and sequences.
// [R19] Double fault (access error) or verify/compress failure drops the buffered command.
// [R20] Failure flag clears on write 1; no launch while it is set.
// [R21] Double-fault flag clears when access error is cleared by write 1.
// [R22] Scenario number is open, high-disable, low-disable bits, msb first.
module flash_protect_status_guard
   import flash_guard_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic special_mode_i,
   input wire logic prot_load_i,
   input wire logic [7:0] prot_init_i,
   input wire engine_evt_s evt_i,
   output cmd_launch_s cmd_launch_o,
   output logic cbe_irq_o,
   output logic cc_irq_o
);
   logic [7:0] prot;
   logic [7:0] cfg;
   logic [6:0] cmd_code;
   logic [6:0] pend_code;
   logic [6:0] act_code;
   logic pend;
   logic active;
   logic cbe;
   logic cmd_complete_flag;
   logic pv;
   logic ae;
   logic df;
   logic blank;
   logic fail;
   seq_e seq;
   logic next_cbe;
   logic next_pend;
   logic next_active;
   logic wr_en;
   logic st_wr;
   logic cfg_wr;
   logic prot_wr;
   logic cmd_wr;
   logic blocked;
   logic launch;
   logic abort0;
   logic seq_err;
   logic bad_code;
   logic word_start;
   logic pv_set;
   logic ae_set;
   logic fetch;
   logic drop;
   logic step_ok;
   logic [2:0] cur_scn;
   logic [2:0] new_scn;
   logic [7:0] status_rd;

   // true for the four codes the engine can execute
   function automatic logic legal_code(input logic [6:0] c);
      return (c == CMD_VERIFY) || (c == CMD_COMPRESS) || (c == CMD_PROGRAM) || (c == CMD_SECTOR);
   endfunction

   // register decode, writes land at the edge that completes the access phase
   assign wr_en = psel_i & penable_i & pready_o & pwrite_i & pstrb_i[0];
   assign st_wr = wr_en & (paddr_i == STATUS_ADDR);
   assign cfg_wr = wr_en & (paddr_i == CONFIG_ADDR);
   assign prot_wr = wr_en & (paddr_i == PROT_ADDR);
   assign cmd_wr = wr_en & (paddr_i == CMD_ADDR);

   // scenario numbers for the transition check
   assign cur_scn = {prot[PR_OPEN], prot[PR_HDIS], prot[PR_LDIS]}; // [R22]
   assign new_scn = {pwdata_i[PR_OPEN], pwdata_i[PR_HDIS], pwdata_i[PR_LDIS]}; // [R22]

   protection_step_filter u_step (
      .cur_i(cur_scn),
      .tgt_i(new_scn),
      .ok_o(step_ok)
   );

   // sequence bookkeeping; errors abort the sequence and set access error
   assign blocked = pv | ae; // [R16] [R18]
   assign word_start = evt_i.word_wr & (seq == SEQ_IDLE) & cbe & ~blocked; // [R16] [R18]
   assign pv_set = word_start & evt_i.word_prot; // [R15]
   assign abort0 = st_wr & ~pwdata_i[ST_CBE] & (seq != SEQ_IDLE); // [R9] [R10]
   assign bad_code = cmd_wr & (seq == SEQ_WORD) & ~blocked & ~legal_code(pwdata_i[6:0]);
   assign seq_err = ~blocked & ((cmd_wr & (seq != SEQ_WORD))
                    | (st_wr & pwdata_i[ST_CBE] & (seq == SEQ_WORD))
                    | (evt_i.word_wr & (seq != SEQ_IDLE)));
   assign launch = st_wr & pwdata_i[ST_CBE] & cbe & (seq == SEQ_CMD) & ~blocked & ~fail; // [R8] [R20]
   assign ae_set = seq_err | abort0 | bad_code | evt_i.sector_abort | evt_i.double_fault
                   | (evt_i.stop_entry & ~cmd_complete_flag); // [R17]
   // a fault throws away whatever waits in the command buffer
   assign drop = evt_i.double_fault | (evt_i.cmd_done & evt_i.verify_fail
                 & ((act_code == CMD_VERIFY) | (act_code == CMD_COMPRESS))); // [R19]
   // buffered command moves to the engine only when nothing blocks it
   assign fetch = pend & (~active | evt_i.cmd_done) & ~ae & ~pv & ~fail & ~drop; // [R16] [R18] [R20]

   // buffer occupancy: empty flag follows the buffer, pending follows launch
   always_comb begin
      next_pend = pend;
      next_active = active;
      next_cbe = cbe;
      if (evt_i.cmd_done) begin
         next_active = 1'b0;
      end
      if (fetch) begin
         next_active = 1'b1;
         next_pend = 1'b0;
         next_cbe = 1'b1;
      end else if (drop & pend) begin
         next_pend = 1'b0;
         next_cbe = 1'b1;
      end
      if (launch) begin
         next_pend = 1'b1;
         next_cbe = 1'b0; // [R8]
      end
   end

   // sequence state machine
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         seq <= SEQ_IDLE;
      end else if (ce_i) begin
         if (ae_set | pv_set) begin
            seq <= SEQ_IDLE; // [R9]
         end else begin
            unique case (seq)
               SEQ_IDLE: begin
                  if (word_start) begin
                     seq <= SEQ_WORD;
                  end
               end
               SEQ_WORD: begin
                  if (cmd_wr) begin
                     seq <= SEQ_CMD;
                  end
               end
               SEQ_CMD: begin
                  if (launch) begin
                     seq <= SEQ_IDLE;
                  end
               end
            endcase
         end
      end
   end

   // command buffer and active command
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cmd_code <= CMD_RESET;
         pend_code <= CMD_RESET;
         act_code <= CMD_RESET;
         pend <= 1'b0;
         active <= 1'b0;
         cbe <= 1'b1;
         cmd_complete_flag <= 1'b1;
      end else if (ce_i) begin
         if (cmd_wr & (seq == SEQ_WORD) & ~blocked) begin
            cmd_code <= pwdata_i[6:0];
         end
         if (launch) begin
            pend_code <= cmd_code;
         end
         if (fetch) begin
            act_code <= pend_code;
         end
         pend <= next_pend;
         active <= next_active;
         cbe <= next_cbe;
         // taken from next values so a back-to-back fetch never flashes it
         cmd_complete_flag <= next_cbe & ~next_active & ~next_pend; // [R12] [R13] [R14]
      end
   end

   // error flags: hardware set wins over a software clear in the same cycle
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pv <= 1'b0;
         ae <= 1'b0;
         df <= 1'b0;
      end else if (ce_i) begin
         pv <= pv_set | (pv & ~(st_wr & pwdata_i[ST_PV])); // [R15]
         ae <= ae_set | (ae & ~(st_wr & pwdata_i[ST_AE])); // [R18]
         df <= evt_i.double_fault | (df & ~(st_wr & pwdata_i[ST_AE])); // [R21]
      end
   end

   // verify result and failure flag
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         blank <= 1'b0;
         fail <= 1'b0;
      end else if (ce_i) begin
         if (evt_i.cmd_done & (act_code == CMD_VERIFY)) begin
            blank <= evt_i.blank;
         end else if (launch) begin
            blank <= 1'b0;
         end
         fail <= (evt_i.cmd_done & evt_i.verify_fail) | evt_i.double_fault
                 | (fail & ~(st_wr & pwdata_i[ST_FAIL] & special_mode_i)); // [R6] [R20]
      end
   end

   // protection setting; on a bus write, size fields move only while their disable bit is set
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         prot <= PROT_RESET;
      end else if (ce_i) begin
         if (prot_load_i) begin
            prot <= prot_init_i;
         end else if (prot_wr & step_ok) begin // [R1]
            prot[PR_OPEN] <= pwdata_i[PR_OPEN];
            prot[PR_HDIS] <= pwdata_i[PR_HDIS];
            prot[PR_LDIS] <= pwdata_i[PR_LDIS];
            if (prot[PR_HDIS]) begin
               prot[PR_HS_LO +: 2] <= pwdata_i[PR_HS_LO +: 2];
            end
            if (prot[PR_LDIS]) begin
               prot[PR_LS_LO +: 2] <= pwdata_i[PR_LS_LO +: 2];
            end
         end
      end
   end

   // interrupt enables
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cfg <= CONFIG_RESET;
      end else if (ce_i && cfg_wr) begin
         cfg <= {pwdata_i[CFG_BUFFER_EMPTY_IRQ_ENABLE], pwdata_i[CFG_COMPLETE_IRQ_ENABLE], 6'h00};
      end
   end

   // complete and blank are read only, bit 0 reads zero
   assign status_rd = {cbe, cmd_complete_flag, pv, ae, df, blank, fail, 1'b0}; // [R5]

   // apb answer: ready one cycle after setup, so each access has one wait-free access phase
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pready_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end else if (ce_i) begin
         pready_o <= psel_i & ~penable_i;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
         if (psel_i & ~penable_i) begin
            unique case (paddr_i)
               STATUS_ADDR: prdata_o <= {24'h00_0000, status_rd};
               CONFIG_ADDR: prdata_o <= {24'h00_0000, cfg};
               PROT_ADDR: prdata_o <= {24'h00_0000, prot[7], 1'b1, prot[5:0]}; // [R4]
               CMD_ADDR: prdata_o <= {25'h000_0000, cmd_code};
               default: pslverr_o <= 1'b1;
            endcase
         end
      end
   end

   // engine launch pulse and interrupt requests
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cmd_launch_o <= '0;
         cbe_irq_o <= 1'b0;
         cc_irq_o <= 1'b0;
      end else if (ce_i) begin
         cmd_launch_o.valid <= fetch;
         cmd_launch_o.code <= pend_code;
         cbe_irq_o <= cbe & cfg[CFG_BUFFER_EMPTY_IRQ_ENABLE]; // [R11]
         cc_irq_o <= cmd_complete_flag & cfg[CFG_COMPLETE_IRQ_ENABLE]; // [R14]
      end
   end

   a_prot_reject: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R1]
      ce_i && prot_wr && !step_ok && !prot_load_i |=> prot == $past(prot))
      else $error("protection changed on a refused write");
   a_prot_three: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R2]
      ce_i && !prot_load_i && cur_scn == 3'd3 |=> {prot[7], prot[5], prot[2]} == 3'd3)
      else $error("scenario 3 was left");
   a_prot_open: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R3]
      ce_i && prot_wr && !prot_load_i && cur_scn == 3'd7 |=> {prot[7], prot[5], prot[2]} == $past(new_scn))
      else $error("scenario 7 refused a change");
   a_abort_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R9]
      ce_i && abort0 |=> ae && seq == SEQ_IDLE)
      else $error("mid-sequence zero write did not abort");
   a_cc_follows: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R12]
      ce_i && active && !evt_i.cmd_done |=> !cmd_complete_flag)
      else $error("complete flag set while a command still runs");
   a_pv_blocks: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R16]
      ce_i && pv |=> !cmd_launch_o.valid)
      else $error("launch under protection violation");
   a_ae_blocks: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R18]
      ce_i && ae |=> !cmd_launch_o.valid)
      else $error("launch under access error");
   a_fail_blocks: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R20]
      ce_i && fail |=> !cmd_launch_o.valid)
      else $error("launch while failure flag set");
   a_fail_normal: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R6]
      ce_i && fail && st_wr && !special_mode_i |=> fail)
      else $error("failure flag cleared outside special mode");
   a_df_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R21]
      ce_i && st_wr && pwdata_i[ST_AE] && !evt_i.double_fault |=> !df)
      else $error("double fault not cleared with access error");
   a_cc_irq: assert property (@(posedge clk_i) disable iff (sys_rst_i) // [R14]
      ce_i && cmd_complete_flag && cfg[CFG_COMPLETE_IRQ_ENABLE] |=> cc_irq_o)
      else $error("complete interrupt missing");
endmodule
`default_nettype wire

/* File: core/flash_guard_pkg.sv */
package flash_guard_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] STATUS_IDX = 8'h05;
   localparam logic [7:0] CONFIG_IDX = 8'h03;
   localparam logic [7:0] PROT_IDX = 8'h04;
   localparam logic [7:0] CMD_IDX = 8'h06;
   localparam logic [7:0] STATUS_ADDR = 8'(STATUS_IDX * 4);
   localparam logic [7:0] CONFIG_ADDR = 8'(CONFIG_IDX * 4);
   localparam logic [7:0] PROT_ADDR = 8'(PROT_IDX * 4);
   localparam logic [7:0] CMD_ADDR = 8'(CMD_IDX * 4);
   // status bit positions
   localparam int ST_CBE = 7;
   localparam int ST_CC = 6;
   localparam int ST_PV = 5;
   localparam int ST_AE = 4;
   localparam int ST_DF = 3;
   localparam int ST_BLANK = 2;
   localparam int ST_FAIL = 1;
   // configuration bit positions
   localparam int CFG_BUFFER_EMPTY_IRQ_ENABLE = 7;
   localparam int CFG_COMPLETE_IRQ_ENABLE = 6;
   // protection setting fields
   localparam int PR_OPEN = 7;
   localparam int PR_RSV = 6;
   localparam int PR_HDIS = 5;
   localparam int PR_HS_LO = 3;
   localparam int PR_LDIS = 2;
   localparam int PR_LS_LO = 0;
   // reset values
   localparam logic [7:0] PROT_RESET = 8'hff;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [6:0] CMD_RESET = 7'h00;
   // legal command codes
   localparam logic [6:0] CMD_VERIFY = 7'h05;
   localparam logic [6:0] CMD_COMPRESS = 7'h06;
   localparam logic [6:0] CMD_PROGRAM = 7'h20;
   localparam logic [6:0] CMD_SECTOR = 7'h40;
   // allowed targets per scenario, bit n set means scenario n reachable
   localparam logic [7:0] PROT_ALLOW [8] = '{8'h0f, 8'h0a, 8'h0c, 8'h08, 8'h18, 8'h3c, 8'h5a, 8'hff};

   typedef enum {SEQ_IDLE, SEQ_WORD, SEQ_CMD} seq_e;

   // events reported by the flash array engine, one-cycle pulses
   typedef struct packed {
      logic word_wr;      // aligned word written to flash space
      logic word_prot;    // that word hit a protected address
      logic cmd_done;     // active command finished
      logic blank;        // erase verify result, valid with cmd_done
      logic verify_fail;  // erase verify or compress failed, with cmd_done
      logic double_fault;
      logic sector_abort; // sector erase cut short by an abort
      logic stop_entry;
   } engine_evt_s;

   typedef struct packed {
      logic valid;
      logic [6:0] code;
   } cmd_launch_s;
endpackage

/* File: core/protection_step_filter.sv */
`timescale 1ns/100ps
`default_nettype none
// decides whether a protection scenario change only adds protection
module protection_step_filter
   import flash_guard_pkg::*;
(
   input wire logic [2:0] cur_i,
   input wire logic [2:0] tgt_i,
   output logic ok_o
);
   // one row of the transition table per current scenario
   always_comb begin
      ok_o = PROT_ALLOW[cur_i][tgt_i]; // [R2] [R3]
   end
endmodule
`default_nettype wire

/* File: tb/flash_engine_model.sv */
`timescale 1ns/100ps
`default_nettype none
// behavioural flash array engine: echoes bench event requests and
// finishes each launched command after a programmable number of cycles
module flash_engine_model
   import flash_guard_pkg::*;
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire cmd_launch_s launch_i,
   input wire engine_evt_s req_i,
   input wire logic [3:0] lat_i,
   output engine_evt_s evt_o
);
   logic busy;
   logic [3:0] cnt;

   // one command at a time; lat_i of 0 answers promptly, larger is slow
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         busy <= 1'b0;
         cnt <= 4'h0;
         evt_o <= '0;
      end else begin
         evt_o <= req_i;
         if (launch_i.valid) begin
            busy <= 1'b1;
            cnt <= lat_i;
         end else if (busy && cnt == 4'h0) begin
            busy <= 1'b0;
            evt_o.cmd_done <= 1'b1; // done pulse lasts one cycle
         end else if (busy) begin
            cnt <= cnt - 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

/* File: tb/flash_protect_status_guard_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module flash_protect_status_guard_tb
   import flash_guard_pkg::*;
();
   logic clk_i, sys_rst_i, psel, penable, pwrite, special, prot_load;
   logic pready, pslverr, cbe_irq, cc_irq, err;
   logic [7:0] paddr, prot_init;
   logic [31:0] pwdata, prdata, r;
   logic [3:0] lat;
   engine_evt_s evt, req;
   cmd_launch_s launch;
   logic [6:0] last_code;
   int bad_count, num_checks, launches, cc_rises, mark_l, mark_c;
   // reachable targets per scenario, bit n for scenario n
   localparam logic [7:0] ALLOW [8] = '{8'h0f, 8'h0a, 8'h0c, 8'h08, 8'h18, 8'h3c, 8'h5a, 8'hff};

   flash_protect_status_guard DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .special_mode_i(special),
      .prot_load_i(prot_load), .prot_init_i(prot_init), .evt_i(evt), .cmd_launch_o(launch),
      .cbe_irq_o(cbe_irq), .cc_irq_o(cc_irq));
   flash_engine_model ENG (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .launch_i(launch), .req_i(req),
      .lat_i(lat), .evt_o(evt));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   // launch pulse stands one cycle, so the falling edge sees it once
   always @(negedge clk_i) begin
      if (launch.valid === 1'b1) begin
         launches++;
         last_code = launch.code;
      end
   end

   // complete interrupt rises once per return to idle; an extra rise means it flashed
   always @(posedge cc_irq) begin
      cc_rises++;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // one apb transfer; request held until pready is sampled high at a rising edge,
   // answer taken at that edge, then one idle edge so psel is never set twice at once
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      do begin
         @(posedge clk_i);
      end while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(r, e);
   endtask

   // engine event pulses pass one register stage in the model
   task automatic ev(input logic [7:0] e);
      req <= engine_evt_s'(e);
      @(posedge clk_i);
      req <= '0;
      repeat (3) @(posedge clk_i);
   endtask

   function automatic logic [31:0] pb(input logic [2:0] s);
      return {24'h0, s[2], 1'b1, s[1], 2'b11, s[0], 2'b11};
   endfunction

   // one command write sequence: word, command code, then buffer-empty clear
   task automatic load(input logic [6:0] c);
      ev(8'h80);
      apb(1'b1, CMD_ADDR, {25'h0, c});
      apb(1'b1, STATUS_ADDR, 32'h80);
   endtask

   // a full sequence; expect one launch and completion
   task automatic seq(input logic [6:0] c);
      int n0, n;
      n0 = launches;
      n = 0;
      load(c);
      while (launches == n0 && n < 30) begin
         @(posedge clk_i);
         n++;
      end
      chk(32'(launches), 32'(n0 + 1));
      chk({25'h0, last_code}, {25'h0, c});
      apb(1'b0, STATUS_ADDR, 32'h0);
      if (lat > 4'h4)
         chk({31'h0, r[ST_CC]}, 32'h0);
      n = 0;
      do begin
         apb(1'b0, STATUS_ADDR, 32'h0);
         n++;
      end while (r !== 32'hc0 && n < 20);
      chk(r, 32'hc0);
   endtask

   initial begin
      sys_rst_i = 1'b1;
      {psel, penable, pwrite, special, prot_load} = '0;
      paddr = 8'h0;
      pwdata = 32'h0;
      prot_init = 8'hff;
      req = '0;
      lat = 4'h0;
      repeat (16) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      rchk(STATUS_ADDR, 32'hc0);
      rchk(PROT_ADDR, 32'hff);
      rchk(CONFIG_ADDR, 32'h0);
      apb(1'b0, 8'h00, 32'h0);
      chk({31'h0, err}, 32'h1);
      // every from/to pair; the reset-sequence load sets the start scenario
      for (int f = 0; f < 8; f++) begin
         for (int t = 0; t < 8; t++) begin
            prot_init <= 8'(pb(3'(f)));
            prot_load <= 1'b1;
            @(posedge clk_i);
            prot_load <= 1'b0;
            @(posedge clk_i);
            apb(1'b1, PROT_ADDR, pb(3'(t)));
            rchk(PROT_ADDR, ALLOW[f][t] ? pb(3'(t)) : pb(3'(f)));
         end
      end
      apb(1'b1, CONFIG_ADDR, 32'hc0);
      repeat (2) @(posedge clk_i);
      chk({31'h0, cbe_irq}, 32'h1);
      chk({31'h0, cc_irq}, 32'h1);
      lat <= 4'ha;
      seq(CMD_PROGRAM);
      // second command waits in the buffer; its fetch must not flash complete
      lat <= 4'hf;
      mark_l = launches;
      mark_c = cc_rises;
      load(CMD_PROGRAM);
      load(CMD_SECTOR);
      repeat (40) @(posedge clk_i);
      chk(32'(launches), 32'(mark_l + 2));
      chk(32'(cc_rises), 32'(mark_c + 1));
      // a double fault throws away the buffered command behind the active one
      mark_l = launches;
      load(CMD_PROGRAM);
      load(CMD_SECTOR);
      ev(8'h04);
      repeat (40) @(posedge clk_i);
      chk(32'(launches), 32'(mark_l + 1));
      rchk(STATUS_ADDR, 32'hda);
      apb(1'b1, STATUS_ADDR, 32'h10);
      special <= 1'b1;
      apb(1'b1, STATUS_ADDR, 32'h02);
      special <= 1'b0;
      rchk(STATUS_ADDR, 32'hc0);
      apb(1'b1, CONFIG_ADDR, 32'h0);
      repeat (2) @(posedge clk_i);
      chk({31'h0, cbe_irq | cc_irq}, 32'h0);
      lat <= 4'h0;
      seq(CMD_SECTOR);
      ev(8'h80);
      apb(1'b1, STATUS_ADDR, 32'h0);
      rchk(STATUS_ADDR, 32'hd0);
      apb(1'b1, STATUS_ADDR, 32'h10);
      rchk(STATUS_ADDR, 32'hc0);
      apb(1'b1, STATUS_ADDR, 32'h40);
      rchk(STATUS_ADDR, 32'hc0);
      ev(8'hc0);
      rchk(STATUS_ADDR, 32'he0);
      // a word write while the violation stands must not open a sequence
      ev(8'h80);
      apb(1'b1, STATUS_ADDR, 32'h0);
      rchk(STATUS_ADDR, 32'he0);
      apb(1'b1, STATUS_ADDR, 32'h20);
      rchk(STATUS_ADDR, 32'hc0);
      ev(8'h80);
      apb(1'b1, CMD_ADDR, 32'h7f);
      rchk(STATUS_ADDR, 32'hd0);
      apb(1'b1, STATUS_ADDR, 32'h10);
      rchk(STATUS_ADDR, 32'hc0);
      ev(8'h04);
      rchk(STATUS_ADDR, 32'hda);
      apb(1'b1, STATUS_ADDR, 32'h10);
      rchk(STATUS_ADDR, 32'hc2);
      apb(1'b1, STATUS_ADDR, 32'h02);
      rchk(STATUS_ADDR, 32'hc2);
      special <= 1'b1;
      apb(1'b1, STATUS_ADDR, 32'h02);
      rchk(STATUS_ADDR, 32'hc0);
      special <= 1'b0;
      seq(CMD_VERIFY);
      conclude();
   end

   // the tests need well under 10000 cycles
   initial begin
      repeat (40000) @(posedge clk_i);
      bad_count++;
      conclude();
   end
endmodule
`default_nettype wire
